// ### tpwm_top.sv
// Top: 8-bit fast and phase-correct PWM waveform unit with register port
// Overview of operation
// RULE1: Fast mode counts to TOP, wraps BOTTOM
// RULE2: Fast mode sets overflow at TOP
// RULE3: Output mode 2 noninverted, 3 inverted
// RULE4: TOP is 0xFF (mode 3) or compare (7)
// RULE5: Pin driven only when direction is output
// RULE6: Fast mode: match sets/clears, wrap restores
// RULE7: Frequency is clock over prescale times 256
// RULE8: Compare at BOTTOM gives one-cycle spike
// RULE9: Compare at MAX gives constant level
// RULE10: Output mode 1 toggles on match; code toggles in fast modes only
// RULE11: Fast mode keeps compare double buffering
// RULE12: Modes 1 and 5 count up and down
// RULE13: Phase mode: clear up-match, set down-match
// RULE14: Phase mode holds TOP one tick, reverses
// RULE15: Phase mode sets overflow at BOTTOM; interrupts
// RULE16: Buffered compare loads at TOP or BOTTOM
`default_nettype none
module tpwm_top
  import tpwm_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_irq,
  output logic o_pin_out,
  output logic o_pin_oe,
  output logic o_tick
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] ctrl_reg;
  logic [7:0] cmp_buf_reg;
  logic [7:0] cmp_reg;
  logic [7:0] cnt_reg;
  logic [1:0] stat_reg;
  logic [1:0] mask_reg;
  logic dir_out_reg;
  logic oc_reg;
  tpwm_dir_e dir_reg;
  logic [PRESC_W-1:0] presc_reg;
  logic tick;

  logic [2:0] wgm;
  logic [1:0] com;
  logic [2:0] cs;
  logic fast_mode;
  logic pc_mode;
  logic [7:0] top;
  logic at_top;
  logic match;
  logic wrap;
  logic ovf_ev;
  logic match_ev;
  logic upd_point;
  logic [PRESC_W-1:0] div_max;

  assign wgm = ctrl_reg[CTRL_WGM_LSB +: 3];
  assign com = ctrl_reg[CTRL_COM_LSB +: 2];
  assign cs = ctrl_reg[CTRL_CS_LSB +: 3];
  assign fast_mode = (wgm == WGM_FAST_FF) || (wgm == WGM_FAST_CMP);
  assign pc_mode = (wgm == WGM_PC_FF) || (wgm == WGM_PC_CMP); // RULE12
  // Modes 5 and 7 take TOP from the active compare
  assign top = wgm[2] ? cmp_reg : CNT_MAX; // RULE4
  assign at_top = (cnt_reg == top);
  assign match = (cnt_reg == cmp_reg);
  assign wrap = tick && fast_mode && at_top; // RULE1

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  always_comb
  begin
    case (cs)
      3'h1: div_max = PRESC_W'(PRESC_1 - 1);
      3'h2: div_max = PRESC_W'(PRESC_8 - 1);
      3'h3: div_max = PRESC_W'(PRESC_32 - 1);
      3'h4: div_max = PRESC_W'(PRESC_64 - 1);
      3'h5: div_max = PRESC_W'(PRESC_128 - 1);
      3'h6: div_max = PRESC_W'(PRESC_256 - 1);
      3'h7: div_max = PRESC_W'(PRESC_1024 - 1);
      default: div_max = '0;
    endcase
  end

  // Clock select 0 stops the timer clock entirely
  assign tick = (cs != 3'h0) && (presc_reg >= div_max); // RULE7

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || tick || cs == 3'h0)
      presc_reg <= '0;
    else
      presc_reg <= presc_reg + 1'b1;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      o_tick <= 1'b0;
    else
      o_tick <= tick;
  end

  // ****************************************************************
  // Counter
  // ****************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      cnt_reg <= CNT_BOTTOM;
      dir_reg <= TPWM_UP;
    end
    else if (i_wr && i_addr == ADDR_CNT)
      cnt_reg <= i_wdata;
    else if (tick)
    begin
      if (fast_mode)
      begin
        if (at_top)
          cnt_reg <= CNT_BOTTOM; // RULE1
        else
          cnt_reg <= cnt_reg + 8'h01;
        dir_reg <= TPWM_UP;
      end
      else if (pc_mode)
      begin
        // TOP stands one tick: the turn steps straight down again
        if (dir_reg == TPWM_UP)
        begin
          if (at_top)
          begin
            dir_reg <= TPWM_DOWN; // RULE14
            if (cnt_reg != CNT_BOTTOM)
              cnt_reg <= cnt_reg - 8'h01;
          end
          else
            cnt_reg <= cnt_reg + 8'h01; // RULE12
        end
        else
        begin
          if (cnt_reg == CNT_BOTTOM || cnt_reg == 8'h01)
            dir_reg <= TPWM_UP;
          if (cnt_reg != CNT_BOTTOM)
            cnt_reg <= cnt_reg - 8'h01; // RULE12
        end
      end
      else
        cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // ****************************************************************
  // Compare double buffer
  // ****************************************************************
  // Fast mode loads at BOTTOM, phase mode at TOP: no mid-period glitch
  assign upd_point = tick && (fast_mode ? at_top : (pc_mode ?
    (at_top && dir_reg == TPWM_UP) : 1'b1)); // RULE16

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      cmp_buf_reg <= CMP_RST;
    else if (i_wr && i_addr == ADDR_CMP)
      cmp_buf_reg <= i_wdata;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      cmp_reg <= CMP_RST;
    else if (upd_point)
      cmp_reg <= cmp_buf_reg; // RULE11 RULE16
  end

  // ****************************************************************
  // Waveform output
  // ****************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      oc_reg <= 1'b0;
    else if (tick)
    begin
      if (fast_mode)
      begin
        if (com == COM_TOGGLE)
        begin
          if (match)
            oc_reg <= ~oc_reg; // RULE10
        end
        // Wrap wins over a match so MAX gives a steady level
        else if (com != COM_OFF && at_top && !match)
          oc_reg <= (com == COM_NONINV); // RULE6 RULE9
        else if (com != COM_OFF && wrap)
          oc_reg <= (com == COM_NONINV); // RULE9
        else if (com != COM_OFF && match)
          oc_reg <= (com == COM_INV); // RULE3 RULE6 RULE8
      end
      else if (pc_mode && com[1] && match)
      begin
        // Up-match clears, down-match sets; inverted swaps
        // The turn at TOP counts as a down-match, so compare at TOP holds
        if (dir_reg == TPWM_UP && !at_top)
          oc_reg <= (com == COM_INV); // RULE13
        else
          oc_reg <= (com == COM_NONINV); // RULE13
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_pin_out <= 1'b0;
      o_pin_oe <= 1'b0;
    end
    else
    begin
      o_pin_out <= oc_reg;
      o_pin_oe <= dir_out_reg && (com != COM_OFF); // RULE5
    end
  end

  // ****************************************************************
  // Events and interrupt
  // ****************************************************************
  assign ovf_ev = tick && ((fast_mode && at_top) ||
    (pc_mode && dir_reg == TPWM_DOWN && cnt_reg == 8'h01) ||
    (!fast_mode && !pc_mode && cnt_reg == CNT_MAX)); // RULE2 RULE15
  assign match_ev = tick && match;

  // Hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      stat_reg <= '0;
    else
    begin
      stat_reg[STAT_OVF] <= ovf_ev || (stat_reg[STAT_OVF] &&
        !(i_wr && i_addr == ADDR_STAT && i_wdata[STAT_OVF]));
      stat_reg[STAT_MATCH] <= match_ev || (stat_reg[STAT_MATCH] &&
        !(i_wr && i_addr == ADDR_STAT && i_wdata[STAT_MATCH]));
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      o_irq <= 1'b0;
    else
      o_irq <= |(stat_reg & mask_reg); // RULE15
  end

  // ****************************************************************
  // Register port
  // ****************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      ctrl_reg <= CTRL_RST;
      mask_reg <= MASK_RST[1:0];
      dir_out_reg <= 1'b0;
    end
    else if (i_wr)
    begin
      case (i_addr)
        ADDR_CTRL: ctrl_reg <= i_wdata;
        ADDR_MASK: mask_reg <= i_wdata[1:0];
        ADDR_DIR: dir_out_reg <= i_wdata[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      case (i_addr)
        ADDR_CTRL: o_rdata <= ctrl_reg;
        ADDR_CMP: o_rdata <= cmp_buf_reg;
        ADDR_CNT: o_rdata <= cnt_reg;
        ADDR_STAT: o_rdata <= {6'h00, stat_reg};
        ADDR_MASK: o_rdata <= {6'h00, mask_reg};
        ADDR_DIR: o_rdata <= {7'h00, dir_out_reg};
        default: o_rdata <= 8'h00;
      endcase
    end
    else
      o_rdata <= 8'h00;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_fast_wrap: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    wrap && !(i_wr && i_addr == ADDR_CNT) |=> cnt_reg == CNT_BOTTOM) // RULE1
    else $error("fast mode did not wrap");
  a_fast_ovf: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    tick && fast_mode && at_top |=> stat_reg[STAT_OVF]) // RULE2
    else $error("overflow not set at top");
  a_top_full: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    wgm == WGM_FAST_FF |-> top == CNT_MAX) // RULE4
    else $error("wrong top");
  a_pin_dir: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !dir_out_reg |=> !o_pin_oe) // RULE5
    else $error("pin driven as input");
  a_wrap_level: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    wrap && com == COM_NONINV && !match |=> oc_reg) // RULE6
    else $error("wrap level wrong");
  a_pc_hold: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    tick && pc_mode && dir_reg == TPWM_UP && at_top
      && cnt_reg != CNT_BOTTOM && !(i_wr && i_addr == ADDR_CNT)
    |=> dir_reg == TPWM_DOWN && cnt_reg == $past(cnt_reg) - 8'h01) // RULE14
    else $error("phase top not held");
  a_irq_level: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    |(stat_reg & mask_reg) |=> o_irq) // RULE15
    else $error("interrupt missing");
  a_buf_hold: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !upd_point |=> cmp_reg == $past(cmp_reg)) // RULE16
    else $error("compare changed mid period");
  a_pc_ovf: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    tick && pc_mode && dir_reg == TPWM_DOWN && cnt_reg == 8'h01
    |=> stat_reg[STAT_OVF]) // RULE15
    else $error("overflow not set at bottom");
  a_pc_bottom: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    tick && pc_mode && dir_reg == TPWM_DOWN && cnt_reg == 8'h01
      && !(i_wr && i_addr == ADDR_CNT)
    |=> cnt_reg == CNT_BOTTOM && dir_reg == TPWM_UP) // RULE12
    else $error("phase bottom not turned");
  a_fast_clear: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    tick && fast_mode && com == COM_NONINV && match && !at_top
    |=> !oc_reg) // RULE3 RULE6
    else $error("noninverted match did not clear");
  a_fast_set: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    tick && fast_mode && com == COM_INV && match && !at_top
    |=> oc_reg) // RULE3
    else $error("inverted match did not set");
  a_toggle_match: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    tick && fast_mode && com == COM_TOGGLE && match
    |=> oc_reg != $past(oc_reg)) // RULE10
    else $error("toggle missing on match");
  a_pc_up_clear: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    tick && pc_mode && com == COM_NONINV && match
      && dir_reg == TPWM_UP && !at_top
    |=> !oc_reg) // RULE13
    else $error("phase up-match did not clear");
  a_pc_down_set: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    tick && pc_mode && com == COM_NONINV && match
      && dir_reg == TPWM_DOWN
    |=> oc_reg) // RULE13
    else $error("phase down-match did not set");
  a_irq_clear: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !(|(stat_reg & mask_reg)) |=> !o_irq) // RULE15
    else $error("interrupt without masked status");
  a_cmp_load: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    upd_point |=> cmp_reg == $past(cmp_buf_reg)) // RULE11 RULE16
    else $error("buffered compare not loaded");
  a_oe_off: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    com == COM_OFF |=> !o_pin_oe) // RULE5
    else $error("pin driven with output off");
  c_fast_wrap: cover property (@(posedge i_sys_clk) wrap);
  c_pc_turn: cover property (@(posedge i_sys_clk)
    tick && pc_mode && at_top);
  c_irq: cover property (@(posedge i_sys_clk) o_irq);
  c_pc_ovf: cover property (@(posedge i_sys_clk)
    tick && pc_mode && dir_reg == TPWM_DOWN && cnt_reg == 8'h01);
  c_toggle: cover property (@(posedge i_sys_clk)
    tick && fast_mode && com == COM_TOGGLE && match);
endmodule : tpwm_top
`default_nettype wire

// ### tpwm_pkg.sv
// Package: register map, field layout and constants of the PWM waveform unit
`default_nettype none
package tpwm_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CMP = 4'h1;
  localparam logic [3:0] ADDR_CNT = 4'h2;
  localparam logic [3:0] ADDR_STAT = 4'h3;
  localparam logic [3:0] ADDR_MASK = 4'h4;
  localparam logic [3:0] ADDR_DIR = 4'h5;
  // Control register fields
  localparam int CTRL_WGM_LSB = 0;
  localparam int CTRL_COM_LSB = 3;
  localparam int CTRL_CS_LSB = 5;
  // Status bits
  localparam int STAT_OVF = 0;
  localparam int STAT_MATCH = 1;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  // Waveform modes
  localparam logic [2:0] WGM_PC_FF = 3'h1;
  localparam logic [2:0] WGM_FAST_FF = 3'h3;
  localparam logic [2:0] WGM_PC_CMP = 3'h5;
  localparam logic [2:0] WGM_FAST_CMP = 3'h7;
  // Output modes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_NONINV = 2'h2;
  localparam logic [1:0] COM_INV = 2'h3;
  // Count extremes
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  // Prescale divisors, clock select 1..7
  localparam int PRESC_1 = 1;
  localparam int PRESC_8 = 8;
  localparam int PRESC_32 = 32;
  localparam int PRESC_64 = 64;
  localparam int PRESC_128 = 128;
  localparam int PRESC_256 = 256;
  localparam int PRESC_1024 = 1024;
  localparam int PRESC_W = 10;
  typedef enum logic [1:0] {
    TPWM_UP = 2'b01,
    TPWM_DOWN = 2'b10
  } tpwm_dir_e;
endpackage : tpwm_pkg
`default_nettype wire

// ### tpwm_load_model.sv
// Load model: external circuit watching the waveform pin
`default_nettype none
module tpwm_load_model
(
  input wire logic i_clk,
  input wire logic i_pin_out,
  input wire logic i_pin_oe,
  output logic o_level,
  output logic [15:0] o_period,
  output logic [15:0] o_hi,
  output logic [15:0] o_rises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev = 1'b0;
  logic [15:0] run = 16'h0000;
  logic [15:0] hrun = 16'h0000;
  initial
  begin
    o_period = 16'h0000;
    o_hi = 16'h0000;
    o_rises = 16'h0000;
  end
  // ***************************************************
  // Pull-down load and edge timing
  // ***************************************************
  // Released pin sits at the pull-down level, never the last value
  assign o_level = i_pin_oe ? i_pin_out : 1'b0;
  always @(posedge i_clk)
  begin
    run <= run + 16'h0001;
    hrun <= o_level ? hrun + 16'h0001 : 16'h0000;
    prev <= o_level;
    if (o_level && !prev)
    begin
      o_period <= run;
      run <= 16'h0001;
      o_rises <= o_rises + 16'h0001;
    end
    if (!o_level && prev)
      o_hi <= hrun;
  end
endmodule : tpwm_load_model
`default_nettype wire

// ### tpwm_top_tb_top.sv
// Testbench: register port, waveform shapes and overflow interrupt
`default_nettype none
module tpwm_top_tb_top
  import tpwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic irq, pin_out, pin_oe, lvl;
  logic tck;
  logic [15:0] period, hi, rises, n;
  logic [7:0] exp_q[$];
  logic [7:0] rv;
  logic [7:0] r;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  int t0;
  int seed = 32'h3565b15f;

  tpwm_top DUT (.i_sys_clk(clk), .i_srst(srst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_tick(tck));
  tpwm_load_model LOAD (.i_clk(clk), .i_pin_out(pin_out),
    .i_pin_oe(pin_oe), .o_level(lvl), .o_period(period), .o_hi(hi),
    .o_rises(rises));

  initial
  begin
    forever #50 clk = ~clk;
  end

  // ***************************************************
  // Shared checks and bus tasks
  // ***************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Expected data is noted now, compared by the watcher two cycles later
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  task automatic pwm(input logic [7:0] c, input logic [7:0] m,
    input logic [15:0] per, input logic [15:0] h);
    wr_reg(ADDR_CMP, m);
    wr_reg(ADDR_CTRL, c);
    // Count may run up to 0xFF before the buffered compare loads
    repeat (3 * per + 300) @(posedge clk);
    chk(period, per);
    chk(hi, h);
    $display("test ctrl=%h cmp=%h done", c, m);
  endtask : pwm

  task final_report;
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    rd_q <= rd;
    if (rd_q)
    begin
      r = exp_q.pop_front();
      chk({8'h00, rdata}, {8'h00, r});
    end
    if (cycles == 60000)
    begin
      err_count++;
      final_report();
    end
  end

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial
  begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd_reg(ADDR_CTRL, CTRL_RST);
    rd_reg(ADDR_CMP, CMP_RST);
    rd_reg(ADDR_STAT, 8'h00);
    rd_reg(ADDR_MASK, MASK_RST);
    rd_reg(ADDR_DIR, 8'h00);
    rd_reg(4'hF, 8'h00);
    rv = $random(seed);
    wr_reg(ADDR_CMP, rv);
    rd_reg(ADDR_CMP, rv);
    $display("test register reset and readback done");
    wr_reg(ADDR_CTRL, 8'h33);
    repeat (10) @(posedge clk);
    chk({15'h0000, pin_oe}, 16'h0000);
    wr_reg(ADDR_DIR, 8'h01);
    repeat (2) @(posedge clk);
    chk({15'h0000, pin_oe}, 16'h0001);
    pwm(8'h33, 8'h00, 16'd256, 16'd1);
    pwm(8'h3B, 8'h00, 16'd256, 16'd255);
    pwm(8'h53, 8'h7F, 16'd2048, 16'd1024);
    n = 16'h0000;
    repeat (80)
    begin
      @(posedge clk);
      n = n + {15'h0000, tck};
    end
    chk(n, 16'd10);
    rd_reg(ADDR_STAT, 8'h03);
    wr_reg(ADDR_CMP, 8'hFF);
    wr_reg(ADDR_CTRL, 8'h33);
    repeat (600) @(posedge clk);
    n = rises;
    repeat (600) @(posedge clk);
    chk(rises, n);
    chk({15'h0000, lvl}, 16'h0001);
    pwm(8'h2F, 8'h00, 16'd2, 16'd1);
    pwm(8'h2F, 8'h31, 16'd100, 16'd50);
    pwm(8'h31, 8'h80, 16'd510, 16'd256);
    pwm(8'h39, 8'h80, 16'd510, 16'd254);
    wr_reg(ADDR_CTRL, 8'h00);
    wr_reg(ADDR_STAT, 8'h03);
    wr_reg(ADDR_MASK, 8'h01);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    wr_reg(ADDR_CMP, 8'h09);
    wr_reg(ADDR_CTRL, 8'h25);
    n = 16'h0000;
    while (irq !== 1'b1 && n < 16'd600)
    begin
      @(posedge clk);
      n++;
    end
    chk({15'h0000, irq}, 16'h0001);
    t0 = cycles;
    wr_reg(ADDR_STAT, 8'h03);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    while (irq !== 1'b1 && cycles < t0 + 100)
      @(posedge clk);
    chk(16'(cycles - t0), 16'd18);
    wr_reg(ADDR_MASK, 8'h00);
    repeat (40) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    $display("test overflow interrupt done");
    final_report();
  end
endmodule : tpwm_top_tb_top
`default_nettype wire
